// *** test/iab_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module iab_host import iab_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [2:0]  hsize,
   output logic      [31:0] hwdata
);
   logic tmo;
   initial begin
      {hsel, haddr, htrans, hwrite, hwdata, tmo} = '0;
      hsize = 3'h2;
   end
   // each phase waits for hready under a bound; a stuck bus raises tmo
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      n = 0;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
      htrans <= 2'h0;
      hwdata <= d;
      do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 100);
      r = hrdata;
      if (n >= 50) tmo = 1'b1;
   endtask : xfer
endmodule : iab_host
`default_nettype wire

// *** test/integer_alu_and_branch_unit_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module integer_alu_and_branch_unit_tb import iab_pkg::*;;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, r, a, b, seed;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          mismatches, checked, i;
   iab_op_e     ops[17] = '{OP_ADD, OP_SUBF, OP_AND, OP_ANDC, OP_NAND, OP_NOR, OP_OR, OP_ORC,
      OP_XOR, OP_EQV, OP_EXTSB, OP_EXTSH, OP_MULHWU, OP_MULLW, OP_NEG, OP_DIVWU, OP_CNTLZ};
   iab_alu_branch i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   iab_host i_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   initial begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end
   function logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function logic [31:0] ex(iab_op_e op, logic [31:0] x, logic [31:0] y);
      logic [63:0] p;
      p = {32'h0, x} * {32'h0, y};
      case (op)
         OP_ADD:    return x + y;
         OP_SUBF:   return ~x + y + 32'h1;
         OP_AND:    return x & y;
         OP_ANDC:   return x & ~y;
         OP_NAND:   return ~(x & y);
         OP_NOR:    return ~(x | y);
         OP_OR:     return x | y;
         OP_ORC:    return x | ~y;
         OP_XOR:    return x ^ y;
         OP_EQV:    return ~(x ^ y);
         OP_EXTSB:  return {{24{x[7]}}, x[7:0]};
         OP_EXTSH:  return {{16{x[15]}}, x[15:0]};
         OP_MULHWU: return p[63:32];
         OP_MULLW:  return p[31:0];
         OP_NEG:    return ~x + 32'h1;
         OP_DIVWU:  return x / y;
         default:   for (int k = 31; k >= 0; k--) if (x[k]) return 32'(31 - k);
      endcase
      return 32'h20;
   endfunction : ex
   task chk(logic [31:0] g, logic [31:0] e);
      checked++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task wr(logic [7:0] ad, logic [31:0] d);
      i_host.xfer(1'b1, ad, d, r);
      if (i_host.tmo) give_verdict();
   endtask : wr
   task rd(logic [7:0] ad);
      i_host.xfer(1'b0, ad, 32'h0, r);
      if (i_host.tmo) give_verdict();
   endtask : rd
   // poll busy under a bound, then leave the chosen register in r
   task run(logic [13:0] c, logic [31:0] x, logic [31:0] y, logic [7:0] res);
      int n;
      wr(IAB_OFF_OPA, x);
      wr(IAB_OFF_OPB, y);
      wr(IAB_OFF_CTRL, {18'h0, c});
      for (n = 0; n < 60; n++) begin
         rd(IAB_OFF_STAT);
         if (r[0] === 1'b0) break;
      end
      if (n == 60) begin
         mismatches++;
         give_verdict();
      end
      rd(res);
   endtask : run
   task give_verdict;
      if (i_host.tmo) mismatches++;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : give_verdict
   initial begin
      {mismatches, checked} = '0;
      seed = 32'hd;
      hresetn = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      for (i = 0; i < 68; i++) begin
         seed = lfsr(seed);
         a = seed;
         seed = lfsr(seed);
         // a zero divisor leaves the quotient undefined, so the divide keeps a nonzero one
         b = (i % 4 == 0 && ops[i % 17] != OP_DIVWU) ? 32'h0 : seed | 32'h1;
         run({8'h0, ops[i % 17]}, a >> (i % 33), b, IAB_OFF_RES);
         chk(r, ex(ops[i % 17], a >> (i % 33), b));
      end
      wr(IAB_OFF_XER, 32'h0);
      run(14'h41, 32'hffffffff, 32'h1, IAB_OFF_XER);
      chk(r, 32'h20000000);
      rd(IAB_OFF_CR);
      chk({28'h0, r[31:28]}, 32'h2);
      run(14'h80, 32'h7fffffff, 32'h1, IAB_OFF_XER);
      chk(r, 32'he0000000);
      wr(IAB_OFF_CIA, 32'h100);
      run(14'h228, 32'h0, 32'hffffff, IAB_OFF_NIA);
      chk(r, 32'hfc);
      rd(IAB_OFF_LR);
      chk(r, 32'h104);
      wr(IAB_OFF_CTR, 32'h5);
      wr(IAB_OFF_FLD, 32'h140004);
      run(14'h29, 32'h0, 32'h0, IAB_OFF_CTR);
      chk(r, 32'h5);
      wr(IAB_OFF_FLD, 32'h100004);
      run(14'h29, 32'h0, 32'h0, IAB_OFF_CTR);
      chk(r, 32'h4);
      rd(IAB_OFF_NIA);
      chk(r, 32'h110);
      rd(8'h40);
      chk(r, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      wr(IAB_OFF_XER, 32'h0);
      wr(IAB_OFF_FLD, 32'h8000);
      run(14'h2003, 32'h1234, 32'h0, IAB_OFF_RES);
      chk(r, 32'hffff8000);
      run(14'h05, 32'h1234, 32'h0, IAB_OFF_RES);
      chk(r, 32'h80001234);
      run(14'h14, 32'h3, 32'h0, IAB_OFF_RES);
      chk(r, 32'hfffe8000);
      run(14'h20, 32'h1, 32'h0, IAB_OFF_XER);
      chk(r, 32'h20000000);
      rd(IAB_OFF_RES);
      chk(r, 32'hffff7fff);
      run(14'h07, 32'h5, 32'h0, IAB_OFF_XER);
      chk(r, 32'h0);
      rd(IAB_OFF_RES);
      chk(r, 32'h6);
      run(14'h0a, 32'h8001, 32'h0, IAB_OFF_CR);
      chk(r, 32'h40000000);
      run(14'h0c, 32'h0, 32'h0, IAB_OFF_RES);
      chk(r, 32'h20);
      run(14'h12, 32'hffffffff, 32'hffffffff, IAB_OFF_RES);
      chk(r, 32'h0);
      run(14'h0d, 32'hfffffff9, 32'h2, IAB_OFF_RES);
      chk(r, 32'hfffffffd);
      wr(IAB_OFF_CR, 32'h80000000);
      wr(IAB_OFF_FLD, 32'h04030000);
      run(14'h1426, 32'h0, 32'h0, IAB_OFF_CR);
      chk(r, 32'h90000000);
      wr(IAB_OFF_FLD, 32'h00020000);
      run(14'h27, 32'h0, 32'h0, IAB_OFF_CR);
      chk(r, 32'h90900000);
      wr(IAB_OFF_FLD, 32'h000c0008);
      run(14'h29, 32'h0, 32'h0, IAB_OFF_NIA);
      chk(r, 32'h120);
      wr(IAB_OFF_FLD, 32'h002c0008);
      run(14'h29, 32'h0, 32'h0, IAB_OFF_NIA);
      chk(r, 32'h104);
      wr(IAB_OFF_LR, 32'h203);
      wr(IAB_OFF_FLD, 32'h00140000);
      run(14'h22a, 32'h0, 32'h0, IAB_OFF_NIA);
      chk(r, 32'h200);
      rd(IAB_OFF_LR);
      chk(r, 32'h104);
      wr(IAB_OFF_CTR, 32'h306);
      wr(IAB_OFF_FLD, 32'h00100000);
      run(14'h2b, 32'h0, 32'h0, IAB_OFF_NIA);
      chk(r, 32'h304);
      wr(IAB_OFF_XER, 32'h0);
      run(14'h8e, 32'h5, 32'h0, IAB_OFF_XER);
      chk(r, 32'hc0000000);
      give_verdict();
   end
endmodule : integer_alu_and_branch_unit_tb
`default_nettype wire

// *** verilog/iab_alu_branch.sv ***
`timescale 1ns/1ps
`default_nettype none
module iab_alu_branch import iab_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata
);

   typedef struct packed {
      iab_state_e              st;
      logic [IAB_CTRL_W-1:0]   ctrl;
      logic [31:0]             a;
      logic [31:0]             b;
      logic [31:0]             fld;
      logic [31:0]             current_instr_addr;
      logic [31:0]             cr;
      logic [2:0]              fixed_point_exception_reg;
      logic [31:0]             ctr;
      logic [31:0]             lr;
      logic [31:0]             res;
      logic [31:0]             next_instr_addr;
      logic                    res_wr;
      logic                    taken;
      logic                    ph_valid;
      logic                    ph_wr;
      logic [7:0]              ph_addr;
      logic [31:0]             rdata;
   } iab_top_s;

   iab_top_s    s;
   iab_top_s    n;

   iab_op_e     op;
   logic        oe;
   logic        rc;
   logic        aa;
   logic        lk;
   logic [15:0] imm;
   logic [4:0]  f1;
   logic [4:0]  f2;
   logic [4:0]  f3;
   logic [31:0] simm;
   logic [31:0] ra0;
   logic [31:0] x;
   logic [31:0] y;
   logic        cin;
   logic [32:0] sum;
   logic [31:0] mb;
   logic [63:0] prod_s;
   logic [63:0] prod_u;
   logic [31:0] res;
   logic        ca_wr;
   logic        ov_en;
   logic        rc_en;
   logic        gpr_wr;
   logic        is_div;
   logic        is_br;
   logic        ov;
   logic        so_new;
   logic [2:0]  xer_new;
   logic [31:0] cr_new;
   logic [31:0] ctr_new;
   logic [31:0] lr_new;
   logic [31:0] disp;
   logic [31:0] tgt;
   logic [31:0] nia_new;
   logic        taken;
   logic        cbit_a;
   logic        cbit_b;
   logic        cbit_r;
   logic [5:0]  clz_cnt;
   logic        div_start;
   logic        div_done;
   logic [31:0] div_q;
   logic        div_ovf;
   logic        commit;

   iab_clz u_clz (
      .value (s.a),
      .count (clz_cnt)
   );

   iab_div u_div (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .start     (div_start),
      .is_signed (op == OP_DIVW),
      .dividend  (s.a),
      .divisor   (s.b),
      .done      (div_done),
      .quotient  (div_q),
      .overflow  (div_ovf)
   );

   assign prod_s = $signed(s.a) * $signed(mb);
   assign prod_u = s.a * s.b;

   // datapath: operands, adder, result select and side effects of the held command
   always_comb begin
      op     = iab_op_e'(s.ctrl[IAB_CTL_OP_LSB +: IAB_OP_W]);
      oe     = s.ctrl[IAB_CTL_OE];
      rc     = s.ctrl[IAB_CTL_RC];
      aa     = s.ctrl[IAB_CTL_AA];
      lk     = s.ctrl[IAB_CTL_LK];
      imm    = s.fld[IAB_FLD_IMM_LSB +: 16];
      f1     = s.fld[IAB_FLD_F1_LSB +: 5];
      f2     = s.fld[IAB_FLD_F2_LSB +: 5];
      f3     = s.fld[IAB_FLD_F3_LSB +: 5];
      simm   = {{16{imm[15]}}, imm};
      ra0    = s.ctrl[IAB_CTL_RZ] ? IAB_RST_WORD : s.a;
      mb     = (op == OP_MULLI) ? simm : s.b;
      x      = s.a;
      y      = s.b;
      cin    = 1'b0;
      ca_wr  = 1'b0;
      ov_en  = 1'b0;
      rc_en  = rc;
      gpr_wr = 1'b1;
      is_div = 1'b0;
      is_br  = 1'b0;
      case (op)
         OP_ADD:    ov_en = oe;
         OP_ADDC:   begin ca_wr = 1'b1; ov_en = oe; end
         OP_ADDE:   begin cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe; end
         OP_ADDI:   begin x = ra0; y = simm; rc_en = 1'b0; end
         OP_ADDIC:  begin x = ra0; y = simm; ca_wr = 1'b1; end
         OP_ADDIS:  begin x = ra0; y = {imm, 16'h0000}; rc_en = 1'b0; end
         OP_ADDME:  begin y = 32'hffff_ffff; cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe; end
         OP_ADDZE:  begin y = IAB_RST_WORD; cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe; end
         OP_NEG:    begin x = ~s.a; y = IAB_RST_WORD; cin = 1'b1; ov_en = oe; end
         OP_SUBF:   begin x = ~s.a; cin = 1'b1; ov_en = oe; end
         OP_SUBFC:  begin x = ~s.a; cin = 1'b1; ca_wr = 1'b1; ov_en = oe; end
         OP_SUBFE:  begin x = ~s.a; cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe; end
         OP_SUBFIC: begin x = ~s.a; y = simm; cin = 1'b1; ca_wr = 1'b1; rc_en = 1'b0; end
         OP_SUBFME: begin
            x = ~s.a; y = 32'hffff_ffff; cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe;
         end
         OP_SUBFZE: begin
            x = ~s.a; y = IAB_RST_WORD; cin = s.fixed_point_exception_reg[0]; ca_wr = 1'b1; ov_en = oe;
         end
         OP_ANDI, OP_ANDIS:                rc_en = 1'b1;
         OP_ORI, OP_ORIS, OP_XORI, OP_XORIS, OP_MULLI: rc_en = 1'b0;
         OP_MULLW:  ov_en = oe;
         OP_DIVW, OP_DIVWU: begin is_div = 1'b1; ov_en = oe; end
         OP_CRLOG, OP_MCRF: begin gpr_wr = 1'b0; rc_en = 1'b0; end
         OP_B, OP_BC, OP_BCLR, OP_BCCTR: begin is_br = 1'b1; gpr_wr = 1'b0; rc_en = 1'b0; end
         default: ;
      endcase
      sum = {1'b0, x} + {1'b0, y} + {32'h0000_0000, cin};
      ov  = (x[31] == y[31]) && (sum[31] != x[31]);
      case (op)
         OP_AND:    res = s.a & s.b;
         OP_ANDC:   res = s.a & ~s.b;
         OP_NAND:   res = ~(s.a & s.b);
         OP_NOR:    res = ~(s.a | s.b);
         OP_OR:     res = s.a | s.b;
         OP_ORC:    res = s.a | ~s.b;
         OP_XOR:    res = s.a ^ s.b;
         OP_EQV:    res = ~(s.a ^ s.b);
         OP_ANDI:   res = s.a & {16'h0000, imm};
         OP_ANDIS:  res = s.a & {imm, 16'h0000};
         OP_ORI:    res = s.a | {16'h0000, imm};
         OP_ORIS:   res = s.a | {imm, 16'h0000};
         OP_XORI:   res = s.a ^ {16'h0000, imm};
         OP_XORIS:  res = s.a ^ {imm, 16'h0000};
         OP_CNTLZ:  res = {26'h000_0000, clz_cnt};
         OP_EXTSB:  res = {{24{s.a[7]}}, s.a[7:0]};
         OP_EXTSH:  res = {{16{s.a[15]}}, s.a[15:0]};
         OP_MULHW:  res = prod_s[63:32];
         OP_MULHWU: res = prod_u[63:32];
         OP_MULLW, OP_MULLI: res = prod_s[31:0];
         OP_DIVW, OP_DIVWU:  res = div_q;
         default:   res = sum[31:0];
      endcase
      if (op == OP_MULLW) begin
         ov = (prod_s[63:31] != {33{prod_s[31]}});
      end else if (is_div) begin
         ov = div_ovf;
      end
      // summary overflow is sticky; only software clears it
      so_new  = s.fixed_point_exception_reg[2] | (ov_en & ov);
      xer_new = {so_new, ov_en ? ov : s.fixed_point_exception_reg[1], ca_wr ? sum[32] : s.fixed_point_exception_reg[0]};
      cr_new  = s.cr;
      if (rc_en) begin
         cr_new[31:28] = {res[31], ~res[31] & (|res), ~|res, so_new};
      end
      cbit_a = s.cr[5'd31 - f2];
      cbit_b = s.cr[5'd31 - f3];
      case (iab_crfn_e'(s.ctrl[IAB_CTL_FN_LSB +: 3]))
         CRF_AND:  cbit_r = cbit_a & cbit_b;
         CRF_ANDC: cbit_r = cbit_a & ~cbit_b;
         CRF_EQV:  cbit_r = ~(cbit_a ^ cbit_b);
         CRF_NAND: cbit_r = ~(cbit_a & cbit_b);
         CRF_NOR:  cbit_r = ~(cbit_a | cbit_b);
         CRF_OR:   cbit_r = cbit_a | cbit_b;
         CRF_ORC:  cbit_r = cbit_a | ~cbit_b;
         default:  cbit_r = cbit_a ^ cbit_b;
      endcase
      if (op == OP_CRLOG) begin
         cr_new[5'd31 - f1] = cbit_r;
      end
      if (op == OP_MCRF) begin
         cr_new[{3'd7 - f1[2:0], 2'b00} +: 4] = s.cr[{3'd7 - f2[2:0], 2'b00} +: 4];
      end
      // branch unit: f1 holds the options, f2 selects the condition bit
      ctr_new = s.ctr;
      if (is_br && op != OP_B && !f1[IAB_BO_NODEC]) begin
         ctr_new = s.ctr - 32'h0000_0001;
      end
      taken = (f1[IAB_BO_NOCOND] || (s.cr[5'd31 - f2] == f1[IAB_BO_TRUE])) &&
              (f1[IAB_BO_NODEC] || ((ctr_new != 32'h0000_0000) ^ f1[IAB_BO_CTRZ]));
      if (op == OP_B) begin
         disp  = {{6{s.b[23]}}, s.b[23:0], 2'b00};
         taken = 1'b1;
      end else begin
         disp  = {{16{imm[13]}}, imm[13:0], 2'b00};
      end
      tgt = aa ? disp : s.current_instr_addr + disp;
      if (op == OP_BCLR) begin
         tgt = {s.lr[31:2], 2'b00};
      end else if (op == OP_BCCTR) begin
         tgt = {ctr_new[31:2], 2'b00};
      end
      taken   = taken && is_br;
      nia_new = taken ? tgt : s.current_instr_addr + IAB_INSTR_BYTES;
      lr_new  = (is_br && lk) ? s.current_instr_addr + IAB_INSTR_BYTES : s.lr;
   end

   assign div_start = (s.st == ST_EXEC) && is_div;
   assign commit    = ((s.st == ST_EXEC) && !is_div) || ((s.st == ST_DIV) && div_done);

   function automatic logic [31:0] rd_mux(input logic [7:0] ad, input iab_top_s v);
      case (ad)
         IAB_OFF_CTRL: rd_mux = {{(32-IAB_CTRL_W){1'b0}}, v.ctrl};
         IAB_OFF_OPA:  rd_mux = v.a;
         IAB_OFF_OPB:  rd_mux = v.b;
         IAB_OFF_FLD:  rd_mux = v.fld;
         IAB_OFF_CIA:  rd_mux = v.current_instr_addr;
         IAB_OFF_CR:   rd_mux = v.cr;
         IAB_OFF_XER:  rd_mux = {v.fixed_point_exception_reg, 29'h0000_0000};
         IAB_OFF_CTR:  rd_mux = v.ctr;
         IAB_OFF_LR:   rd_mux = v.lr;
         IAB_OFF_RES:  rd_mux = v.res;
         IAB_OFF_NIA:  rd_mux = v.next_instr_addr;
         IAB_OFF_STAT: rd_mux = {29'h0000_0000, v.taken, v.res_wr, v.st != ST_IDLE};
         default:      rd_mux = 32'h0000_0000;
      endcase
   endfunction : rd_mux

   // bus slave and command sequencing
   always_comb begin
      n = s;
      if (s.ph_valid && s.ph_wr) begin
         case (s.ph_addr)
            IAB_OFF_CTRL: begin
               // a command written while one is running is dropped
               if (s.st == ST_IDLE) begin
                  n.ctrl = hwdata[IAB_CTRL_W-1:0];
                  n.st   = ST_EXEC;
               end
            end
            IAB_OFF_OPA: n.a   = hwdata;
            IAB_OFF_OPB: n.b   = hwdata;
            IAB_OFF_FLD: n.fld = hwdata;
            IAB_OFF_CIA: n.current_instr_addr = hwdata;
            IAB_OFF_CR:  n.cr  = hwdata;
            IAB_OFF_XER: n.fixed_point_exception_reg = hwdata[IAB_XER_SO:IAB_XER_CA];
            IAB_OFF_CTR: n.ctr = hwdata;
            IAB_OFF_LR:  n.lr  = hwdata;
            default: ;
         endcase
      end
      case (s.st)
         ST_IDLE: ;
         ST_EXEC: n.st = is_div ? ST_DIV : ST_IDLE;
         ST_DIV:  n.st = div_done ? ST_IDLE : ST_DIV;
         default: n.st = ST_IDLE;
      endcase
      // a finishing command wins over a software write of the same register
      if (commit) begin
         if (gpr_wr) begin
            n.res = res;
         end
         n.res_wr = gpr_wr;
         n.fixed_point_exception_reg    = xer_new;
         n.cr     = cr_new;
         n.ctr    = ctr_new;
         n.lr     = lr_new;
         n.next_instr_addr    = nia_new;
         n.taken  = taken;
      end
      n.ph_valid = hsel && htrans[1] && hready;
      n.ph_wr    = hwrite;
      n.ph_addr  = haddr[7:0];
      if (haddr[31:8] != 24'h00_0000) begin
         n.ph_addr = 8'hff;
      end
      n.rdata = rd_mux(n.ph_addr, n);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s    <= '0;
         s.st <= ST_IDLE;
      end else begin
         s <= n;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = s.rdata;

   logic fire;
   assign fire = (s.st == ST_EXEC);

   AST_ADD_SUM: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_ADD |=> s.res == $past(s.a) + $past(s.b))
      else $error("add result wrong");
   AST_ADDC_CARRY: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_ADDC |=> s.fixed_point_exception_reg[0] == $past(sum[32]) && s.res_wr)
      else $error("carry not written");
   AST_SUBF_VAL: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_SUBF |=> s.res == $past(s.b) - $past(s.a))
      else $error("subtract-from wrong");
   AST_NEG_VAL: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_NEG |=> s.res == 32'h0000_0000 - $past(s.a))
      else $error("negate wrong");
   AST_ANDI_CR0: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_ANDI |=> s.cr[29] == (s.res == 32'h0000_0000))
      else $error("and-immediate did not update field zero");
   AST_CLZ_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_CNTLZ && s.a == 32'h0000_0000 |=> s.res == 32'h0000_0020)
      else $error("leading zero count of zero wrong");
   AST_EXTSH_VAL: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_EXTSH |=> s.res[31:16] == {16{s.res[15]}})
      else $error("halfword sign extension wrong");
   AST_LINK: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && is_br && lk |=> s.lr == $past(s.current_instr_addr) + IAB_INSTR_BYTES)
      else $error("link not written");
   AST_CTR_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_BC && f1[IAB_BO_NODEC] |=> $stable(s.ctr))
      else $error("counter changed with decrement off");
   AST_DIV_OVF: assert property (@(posedge hclk) disable iff (!hresetn)
      fire && op == OP_DIVWU && oe && s.b == 32'h0000_0000
      |-> ##[33:34] s.fixed_point_exception_reg[2:1] == 2'b11)
      else $error("divide by zero did not set overflow");
   AST_SO_STICKY: assert property (@(posedge hclk) disable iff (!hresetn)
      s.fixed_point_exception_reg[2] && !(s.ph_valid && s.ph_wr && s.ph_addr == IAB_OFF_XER) |=> s.fixed_point_exception_reg[2])
      else $error("summary overflow lost");

endmodule : iab_alu_branch
`default_nettype wire

// *** verilog/iab_clz.sv ***
`timescale 1ns/1ps
`default_nettype none
module iab_clz (
   input  wire logic [31:0] value,
   output logic      [5:0]  count
);

   logic [5:0] acc [0:32];

   assign acc[0] = 6'h00;

   // each all-zero prefix of the word adds one to the count
   for (genvar i = 0; i < 32; i++) begin : g_pre
      assign acc[i+1] = acc[i] + {5'h00, ~|value[31 -: i+1]};
   end

   assign count = acc[32];

endmodule : iab_clz
`default_nettype wire

// *** verilog/iab_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module iab_div import iab_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        start,
   input  wire logic        is_signed,
   input  wire logic [31:0] dividend,
   input  wire logic [31:0] divisor,
   output logic             done,
   output logic      [31:0] quotient,
   output logic             overflow
);

   typedef struct packed {
      logic        busy;
      logic [5:0]  cnt;
      logic [31:0] rem;
      logic [31:0] q;
      logic [31:0] d;
      logic        neg;
      logic        ovf;
      logic        done;
   } iab_div_s;

   iab_div_s   s;
   iab_div_s   n;
   logic [32:0] sh;
   logic [32:0] diff;
   logic [31:0] qn;

   // restoring divide on magnitudes, one quotient bit a cycle
   always_comb begin
      n      = s;
      n.done = 1'b0;
      sh     = {s.rem, s.q[31]};
      diff   = sh - {1'b0, s.d};
      qn     = {s.q[30:0], ~diff[32]};
      if (start && !s.busy) begin
         n.busy = 1'b1;
         n.cnt  = 6'h00;
         n.rem  = 32'h0000_0000;
         n.q    = (is_signed && dividend[31]) ? -dividend : dividend;
         n.d    = (is_signed && divisor[31]) ? -divisor : divisor;
         n.neg  = is_signed && (dividend[31] ^ divisor[31]);
         n.ovf  = (divisor == 32'h0000_0000) ||
                  (is_signed && dividend == 32'h8000_0000 && divisor == 32'hffff_ffff);
      end else if (s.busy) begin
         n.rem = diff[32] ? sh[31:0] : diff[31:0];
         n.q   = qn;
         n.cnt = s.cnt + 6'h01;
         if (s.cnt == IAB_DIV_CYCLES - 6'h01) begin
            n.busy = 1'b0;
            n.done = 1'b1;
            n.q    = s.neg ? -qn : qn;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign done     = s.done;
   assign quotient = s.q;
   assign overflow = s.ovf;

endmodule : iab_div
`default_nettype wire

// *** verilog/iab_pkg.sv ***
`default_nettype none
package iab_pkg;

   localparam int unsigned IAB_DW = 32;

   // register byte offsets on the bus
   localparam logic [7:0] IAB_OFF_CTRL = 8'h00;
   localparam logic [7:0] IAB_OFF_OPA  = 8'h04;
   localparam logic [7:0] IAB_OFF_OPB  = 8'h08;
   localparam logic [7:0] IAB_OFF_FLD  = 8'h0c;
   localparam logic [7:0] IAB_OFF_CIA  = 8'h10;
   localparam logic [7:0] IAB_OFF_CR   = 8'h14;
   localparam logic [7:0] IAB_OFF_XER  = 8'h18;
   localparam logic [7:0] IAB_OFF_CTR  = 8'h1c;
   localparam logic [7:0] IAB_OFF_LR   = 8'h20;
   localparam logic [7:0] IAB_OFF_RES  = 8'h24;
   localparam logic [7:0] IAB_OFF_NIA  = 8'h28;
   localparam logic [7:0] IAB_OFF_STAT = 8'h2c;

   // command register layout
   localparam int unsigned IAB_OP_W       = 6;
   localparam int unsigned IAB_CTRL_W     = 14;
   localparam int unsigned IAB_CTL_OP_LSB = 0;
   localparam int unsigned IAB_CTL_RC     = 6;
   localparam int unsigned IAB_CTL_OE     = 7;
   localparam int unsigned IAB_CTL_AA     = 8;
   localparam int unsigned IAB_CTL_LK     = 9;
   localparam int unsigned IAB_CTL_FN_LSB = 10;
   localparam int unsigned IAB_CTL_RZ     = 13;

   // instruction field register layout
   localparam int unsigned IAB_FLD_IMM_LSB = 0;
   localparam int unsigned IAB_FLD_F1_LSB  = 16;
   localparam int unsigned IAB_FLD_F2_LSB  = 21;
   localparam int unsigned IAB_FLD_F3_LSB  = 26;

   // fixed_point_exception_reg bits as seen on the bus
   localparam int unsigned IAB_XER_SO = 31;
   localparam int unsigned IAB_XER_OV = 30;
   localparam int unsigned IAB_XER_CA = 29;

   // branch_options bits, numbered from the lsb
   localparam int unsigned IAB_BO_NOCOND = 4;
   localparam int unsigned IAB_BO_TRUE   = 3;
   localparam int unsigned IAB_BO_NODEC  = 2;
   localparam int unsigned IAB_BO_CTRZ   = 1;

   localparam logic [31:0] IAB_RST_WORD    = 32'h0000_0000;
   localparam logic [31:0] IAB_INSTR_BYTES = 32'h0000_0004;
   localparam logic [5:0]  IAB_DIV_CYCLES  = 6'h20;

   typedef enum logic [5:0] {
      OP_ADD    = 6'h00, OP_ADDC   = 6'h01, OP_ADDE   = 6'h02, OP_ADDI  = 6'h03,
      OP_ADDIC  = 6'h04, OP_ADDIS  = 6'h05, OP_ADDME  = 6'h06, OP_ADDZE = 6'h07,
      OP_AND    = 6'h08, OP_ANDC   = 6'h09, OP_ANDI   = 6'h0a, OP_ANDIS = 6'h0b,
      OP_CNTLZ  = 6'h0c, OP_DIVW   = 6'h0d, OP_DIVWU  = 6'h0e, OP_EQV   = 6'h0f,
      OP_EXTSB  = 6'h10, OP_EXTSH  = 6'h11, OP_MULHW  = 6'h12, OP_MULHWU = 6'h13,
      OP_MULLI  = 6'h14, OP_MULLW  = 6'h15, OP_NAND   = 6'h16, OP_NEG   = 6'h17,
      OP_NOR    = 6'h18, OP_OR     = 6'h19, OP_ORC    = 6'h1a, OP_ORI   = 6'h1b,
      OP_ORIS   = 6'h1c, OP_SUBF   = 6'h1d, OP_SUBFC  = 6'h1e, OP_SUBFE = 6'h1f,
      OP_SUBFIC = 6'h20, OP_SUBFME = 6'h21, OP_SUBFZE = 6'h22, OP_XOR   = 6'h23,
      OP_XORI   = 6'h24, OP_XORIS  = 6'h25, OP_CRLOG  = 6'h26, OP_MCRF  = 6'h27,
      OP_B      = 6'h28, OP_BC     = 6'h29, OP_BCLR   = 6'h2a, OP_BCCTR = 6'h2b
   } iab_op_e;

   typedef enum logic [2:0] {
      CRF_AND = 3'h0, CRF_ANDC = 3'h1, CRF_EQV = 3'h2, CRF_NAND = 3'h3,
      CRF_NOR = 3'h4, CRF_OR   = 3'h5, CRF_ORC = 3'h6, CRF_XOR  = 3'h7
   } iab_crfn_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_DIV  = 2'b10
   } iab_state_e;

endpackage : iab_pkg
`default_nettype wire
